/* File: hlt_pkg.sv */
package hlt_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int HLT_W = 8;
    localparam int HLT_MODE_W = 5;

    // ------------------------------------------------------------
    // mode codes
    // ------------------------------------------------------------
    localparam logic [4:0] MODE_SW_GATE = 5'h00;
    localparam logic [4:0] MODE_GATE_HI_STOP = 5'h01;
    localparam logic [4:0] MODE_GATE_LO_STOP = 5'h02;
    localparam logic [4:0] MODE_EDGE_ANY_RST = 5'h03;
    localparam logic [4:0] MODE_EDGE_RISE_RST = 5'h04;
    localparam logic [4:0] MODE_EDGE_FALL_RST = 5'h05;
    localparam logic [4:0] MODE_LEVEL_LO_RST = 5'h06;
    localparam logic [4:0] MODE_LEVEL_HI_RST = 5'h07;
    localparam logic [4:0] MODE_ONESHOT_SW = 5'h08;
    localparam logic [4:0] MODE_ONESHOT_RISE = 5'h09;
    localparam logic [4:0] MODE_ONESHOT_FALL = 5'h0A;
    localparam logic [4:0] MODE_ONESHOT_ANY = 5'h0B;

    // ------------------------------------------------------------
    // register map (word offsets as byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PERIOD = 4'h4;
    localparam logic [3:0] REG_PULSE = 4'h8;
    localparam logic [3:0] REG_COUNT = 4'hC;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_MODE_LSB = 8;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [7:0] PULSE_RST = 8'h00;
    localparam logic [4:0] MODE_RST = 5'h00;
    localparam int SYNC_STAGES = 2;
endpackage : hlt_pkg

/* File: hlt_ctl_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface hlt_ctl_if;
    logic run;
    logic ext_sync;
    logic ext_rise;
    logic ext_fall;
    modport src (output run, output ext_sync, output ext_rise, output ext_fall);
    modport dst (input run, input ext_sync, input ext_rise, input ext_fall);
endinterface : hlt_ctl_if
`default_nettype wire

/* File: hlt_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module hlt_sync
    import hlt_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // raw levels
    input wire logic run_raw_in,
    input wire logic ext_raw_in,
    // synchronised view
    hlt_ctl_if.src ctl
);
    logic [1:0] run_q;
    logic [1:0] ext_q;
    logic ext_prev;

    // two flops each; first stage is read only by the second
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            run_q <= 2'h0;
            ext_q <= 2'h0;
            ext_prev <= 1'b0;
        end else begin
            run_q <= {run_q[0], run_raw_in};
            ext_q <= {ext_q[0], ext_raw_in};
            ext_prev <= ext_q[1];
        end
    end

    assign ctl.run = run_q[1];
    assign ctl.ext_sync = ext_q[1];
    assign ctl.ext_rise = ext_q[1] & ~ext_prev;
    assign ctl.ext_fall = ~ext_q[1] & ext_prev;
endmodule : hlt_sync
`default_nettype wire

/* File: hlt_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module hlt_timer
    import hlt_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // avalon-mm slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // external reset/gate input
    input wire logic ext_reset_input_in,
    // timer outputs
    output logic [7:0] count_value_out,
    output logic period_match_out,
    output logic pwm_out
);
    typedef enum logic [1:0] {HLT_IDLE, HLT_ARMED, HLT_RUN} hlt_os_t;

    hlt_ctl_if ctl ();

    logic run_bit;
    logic [4:0] mode;
    logic [7:0] period_value;
    logic [7:0] pulse_width_value;
    logic [7:0] count_value;
    logic [7:0] next_count;
    logic clear_run;
    logic answered;
    hlt_os_t os_state;
    logic [1:0] rst_hold;
    logic pwm;

    function automatic logic is_oneshot(input logic [4:0] m);
        is_oneshot = (m >= MODE_ONESHOT_SW) && (m <= MODE_ONESHOT_ANY);
    endfunction : is_oneshot

    function automatic logic is_level(input logic [4:0] m);
        is_level = (m == MODE_LEVEL_LO_RST) || (m == MODE_LEVEL_HI_RST);
    endfunction : is_level

    hlt_sync u_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .run_raw_in(run_bit),
        .ext_raw_in(ext_reset_input_in),
        .ctl(ctl)
    );

    // ------------------------------------------------------------
    // bus slave: one wait cycle on every access
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            answered <= 1'b0;
        end else begin
            answered <= (avs_read_in | avs_write_in) & ~answered;
        end
    end

    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~answered;

    logic wr_take;
    assign wr_take = avs_write_in & answered;

    // software write vs hardware clear of run: the clear wins only when no
    // write to the control word lands in the same cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            run_bit <= 1'b0;
            mode <= MODE_RST;
        end else if (wr_take && avs_address_in == REG_CTRL) begin
            if (avs_byteenable_in[0]) begin
                run_bit <= avs_writedata_in[CTRL_RUN_BIT];
            end
            if (avs_byteenable_in[1]) begin
                mode <= avs_writedata_in[CTRL_MODE_LSB +: 5];
            end
        end else if (clear_run) begin
            run_bit <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            period_value <= PERIOD_RST;
            pulse_width_value <= PULSE_RST;
        end else if (wr_take && avs_byteenable_in[0]) begin
            if (avs_address_in == REG_PERIOD) begin
                period_value <= avs_writedata_in[7:0];
            end
            if (avs_address_in == REG_PULSE) begin
                pulse_width_value <= avs_writedata_in[7:0];
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in && !answered) begin
            unique case (avs_address_in)
                REG_CTRL: avs_readdata_out <= {19'h0, mode, 7'h0, run_bit};
                REG_PERIOD: avs_readdata_out <= {24'h0, period_value};
                REG_PULSE: avs_readdata_out <= {24'h0, pulse_width_value};
                REG_COUNT: avs_readdata_out <= {24'h0, count_value};
                default: avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // counter control
    // ------------------------------------------------------------
    logic match;
    logic pulse_match;
    logic edge_sel;
    logic level_rst;
    logic gate_ok;

    assign match = (count_value == period_value);
    assign pulse_match = (count_value == pulse_width_value);

    // edge selection shared by edge-reset and edge-start modes
    always_comb begin
        unique case (mode)
            MODE_EDGE_ANY_RST, MODE_ONESHOT_ANY: edge_sel = ctl.ext_rise | ctl.ext_fall;
            MODE_EDGE_RISE_RST, MODE_ONESHOT_RISE: edge_sel = ctl.ext_rise;
            MODE_EDGE_FALL_RST, MODE_ONESHOT_FALL: edge_sel = ctl.ext_fall;
            default: edge_sel = 1'b0;
        endcase
    end

    // level reset only while run is set
    assign level_rst = ctl.run && is_level(mode)
        && (ctl.ext_sync == (mode == MODE_LEVEL_HI_RST));

    always_comb begin
        unique case (mode)
            MODE_GATE_HI_STOP: gate_ok = ~ctl.ext_sync;
            MODE_GATE_LO_STOP: gate_ok = ctl.ext_sync;
            default: gate_ok = 1'b1;
        endcase
    end

    // one-shot sequencing: idle waits for run, armed waits for an edge (software one-shot skips armed)
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            os_state <= HLT_IDLE;
        end else if (!is_oneshot(mode)) begin
            os_state <= HLT_IDLE;
        end else begin
            unique case (os_state)
                // run_bit gates the stale synchronised run after a match clear
                HLT_IDLE: if (ctl.run && run_bit && mode == MODE_ONESHOT_SW) begin
                    os_state <= HLT_RUN;
                end else if (ctl.run && run_bit) begin
                    os_state <= HLT_ARMED;
                end
                HLT_ARMED: if (!ctl.run) begin
                    os_state <= HLT_IDLE;
                end else if (edge_sel) begin
                    os_state <= HLT_RUN;
                end
                HLT_RUN: if (match) begin
                    os_state <= HLT_IDLE;
                end else if (!ctl.run && mode != MODE_ONESHOT_SW) begin
                    os_state <= HLT_IDLE;
                end
            endcase
        end
    end

    // after a match the hardware clear must travel through the run sync,
    // so the sequencer ignores run until the cleared value has arrived
    assign clear_run = is_oneshot(mode) && os_state == HLT_RUN && match && ctl.run;

    // two-clock hold after a reset level drops, mirrors the reset delay
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_hold <= 2'h0;
        end else if (level_rst) begin
            rst_hold <= 2'h2;
        end else if (rst_hold != 2'h0) begin
            rst_hold <= rst_hold - 2'h1;
        end
    end

    always_comb begin
        next_count = count_value;
        if (is_oneshot(mode)) begin
            if (os_state == HLT_RUN && ctl.run) begin
                next_count = match ? 8'h00 : count_value + 8'h01;
            end
        end else if (level_rst || rst_hold != 2'h0) begin
            next_count = 8'h00;
        end else if (edge_sel) begin
            next_count = 8'h00;
        end else if (ctl.run && gate_ok) begin
            next_count = match ? 8'h00 : count_value + 8'h01;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_value <= 8'h00;
        end else begin
            count_value <= next_count;
        end
    end

    // ------------------------------------------------------------
    // pwm time base output
    // ------------------------------------------------------------
    // high from restart to pulse match; a paused counter holds it
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pwm <= 1'b0;
        end else if (next_count != count_value && pulse_match) begin
            pwm <= 1'b0;
        end else if (next_count == 8'h00 && count_value != 8'h00
                     && !(is_oneshot(mode) && match)) begin
            pwm <= 1'b1;
        end else if (is_oneshot(mode) && os_state != HLT_RUN && next_count == 8'h00
                     && ((mode == MODE_ONESHOT_SW && ctl.run) || edge_sel)
                     && os_state != HLT_IDLE | mode == MODE_ONESHOT_SW) begin
            pwm <= ctl.run;
        end
    end

    assign count_value_out = count_value;
    assign period_match_out = match;
    assign pwm_out = pwm;
endmodule : hlt_timer
`default_nettype wire

/* File: hlt_pwm_model.sv */
`timescale 1ns/100ps
`default_nettype none
module hlt_pwm_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // time base
    input wire logic [7:0] count_value_in,
    input wire logic [7:0] pulse_width_value_in,
    // drive
    output logic pwm_ref_out
);
    logic [7:0] last;
    // drive holds through pauses, so a stopped time base stretches it
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            last <= 8'h00;
            pwm_ref_out <= 1'b0;
        end else begin
            last <= count_value_in;
            if (count_value_in == pulse_width_value_in) begin
                pwm_ref_out <= 1'b0;
            end else if (count_value_in == 8'h00 && last != 8'h00) begin
                pwm_ref_out <= 1'b1;
            end
        end
    end
endmodule : hlt_pwm_model
`default_nettype wire

/* File: hlt_timer_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module hlt_timer_checker (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic [7:0] count_value_out,
    input wire logic period_match_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_req_open;
        $rose(avs_read_in || avs_write_in);
    endsequence
    sequence s_req_wait;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    chk_wait_first: assert property (s_req_open |-> avs_waitrequest_out)
        else $error("no wait in first request cycle");
    chk_wait_answer: assert property (s_req_wait |=> !avs_waitrequest_out)
        else $error("answer late");
    chk_wait_idle: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
        else $error("wait while idle");
    chk_accept_after: assert property ((avs_read_in && !avs_waitrequest_out) |-> $past(avs_waitrequest_out))
        else $error("accepted without wait");
    chk_rdata_stand: assert property (!$past(avs_read_in) |-> $stable(avs_readdata_out))
        else $error("read data moved without read");
    chk_count_step: assert property (!$stable(count_value_out) |-> (count_value_out == $past(count_value_out) + 8'h01 || count_value_out == 8'h00))
        else $error("count jumped");
    chk_match_wrap: assert property (period_match_out |=> (count_value_out == 8'h00 || $stable(count_value_out)))
        else $error("count passed period");
    chk_match_cause: assert property ($rose(period_match_out) |-> (!$stable(count_value_out) || $past(avs_write_in)))
        else $error("match without cause");
endmodule : hlt_timer_checker
bind hlt_timer hlt_timer_checker chk (.clk_in(clk_in), .nrst_in(nrst_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .count_value_out(count_value_out),
    .period_match_out(period_match_out));
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CMP(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
module testbench;
    import hlt_pkg::*;
    logic clk_in = 1'b0, nrst_in = 1'b0, rd = 1'b0, wr = 1'b0, ext = 1'b0, wt, pm, pwm, pref;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdat = 32'h0, rdo, rdat;
    logic [7:0] cnt, s, pw = 8'h00;
    logic pe = 1'b0;
    int err_total = 0, checks = 0, seed = 29364, per, ec;
    always #10 clk_in = ~clk_in;
    hlt_timer dut (.clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
        .avs_readdata_out(rdo), .avs_waitrequest_out(wt), .ext_reset_input_in(ext),
        .count_value_out(cnt), .period_match_out(pm), .pwm_out(pwm));
    hlt_pwm_model far (.clk_in(clk_in), .nrst_in(nrst_in), .count_value_in(cnt),
        .pulse_width_value_in(pw), .pwm_ref_out(pref));
    task end_sim;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    task bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        addr <= a; rd <= !w; wr <= w; wdat <= d;
        // waitrequest and read data are taken at the same rising edge
        do begin
            @(posedge clk_in);
            n++;
        end while (wt !== 1'b0 && n < 20);
        if (wt !== 1'b0) begin err_total++; end_sim(); end
        rdat = rdo;
        rd <= 1'b0; wr <= 1'b0;
    endtask : bus
    task rchk(input logic [3:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        `CMP(rdat, e)
    endtask : rchk
    task ctrl(input logic [4:0] m, input logic r);
        bus(REG_CTRL, 1'b1, {19'h0, m, 7'h0, r});
    endtask : ctrl
    task waitc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : waitc
    task wcnt(input logic [7:0] v);
        int n;
        n = 0;
        while (cnt !== v && n < 600) begin @(negedge clk_in); n++; end
        if (n >= 600) begin err_total++; end_sim(); end
    endtask : wcnt
    initial begin
        waitc(4);
        nrst_in <= 1'b1;
        rchk(REG_PERIOD, {24'h0, PERIOD_RST});
        rchk(REG_PULSE, 32'h0);
        rchk(REG_CTRL, 32'h0);
        rchk(4'h2, 32'h0);
        per = 3 + ($random(seed) & 7);
        pw = per[7:0] >> 1;
        bus(REG_PERIOD, 1'b1, per);
        bus(REG_PULSE, 1'b1, {24'h0, pw});
        ctrl(MODE_SW_GATE, 1'b1);
        wcnt(8'h01);
        ec = 1;
        repeat (3 * per) begin
            @(negedge clk_in);
            ec = (ec == per) ? 0 : ec + 1;
            if (ec == 0) pe = 1'b1;
            else if (ec == pw + 1) pe = 1'b0;
            `CMP(cnt, ec[7:0])
            `CMP(pm, ec == per)
            `CMP(pwm, pe)
            `CMP(pref, pe && ec != 0)
        end
        ctrl(MODE_SW_GATE, 1'b0);
        waitc(4);
        s = cnt;
        waitc(5);
        `CMP(cnt, s)
        bus(REG_PERIOD, 1'b1, 32'hFF);
        for (int m = 1; m <= 2; m++) begin
            ext <= (m == 2);
            ctrl(m[4:0], 1'b1);
            waitc(4);
            ext <= (m == 1);
            waitc(4);
            s = cnt;
            waitc(6);
            `CMP(cnt, s)
            ext <= (m == 2);
            waitc(4);
            `CMP(cnt !== s, 1'b1)
        end
        for (int m = 3; m <= 5; m++) begin
            ext <= (m == 4);
            ctrl(m[4:0], 1'b1);
            waitc(20 + ($random(seed) & 3));
            ext <= ~ext;
            waitc(6);
            `CMP(cnt < 8'h08, m == 3)
            if (m != 3) begin
                waitc(14);
                ext <= ~ext;
                waitc(6);
                `CMP(cnt < 8'h08, 1'b1)
            end
        end
        for (int m = 6; m <= 7; m++) begin
            ext <= (m == 6);
            ctrl(m[4:0], 1'b1);
            waitc(12);
            ext <= (m == 7);
            waitc(6);
            `CMP(cnt, 8'h00)
            ext <= (m == 6);
            waitc(10);
            ctrl(m[4:0], 1'b0);
            waitc(4);
            s = cnt;
            ext <= (m == 7);
            waitc(6);
            `CMP(cnt, s)
            ext <= (m == 6);
        end
        bus(REG_PERIOD, 1'b1, 32'h05);
        ctrl(MODE_ONESHOT_SW, 1'b1);
        wcnt(8'h05);
        waitc(6);
        `CMP(cnt, 8'h00)
        rchk(REG_CTRL, {19'h0, MODE_ONESHOT_SW, 8'h0});
        for (int m = 9; m <= 11; m++) begin
            ext <= (m == 10);
            ctrl(m[4:0], 1'b1);
            waitc(6);
            `CMP(cnt, 8'h00)
            ext <= ~ext;
            wcnt(8'h05);
            waitc(4);
            rchk(REG_CTRL, {19'h0, m[4:0], 8'h0});
        end
        end_sim();
    end
endmodule : testbench
`default_nettype wire
